/* logic/process_alarm_evaluator.sv */
`default_nettype none
module process_alarm_evaluator #(
   parameter int CYCLES_PER_SEC = alarm_pkg::CYCLES_PER_SEC
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic signed [15:0] process_value_in,
   input wire logic signed [15:0] set_point_in,
   input wire logic signed [15:0] remote_set_point_in,
   input wire logic signed [15:0] manipulated_variable_in,
   input wire logic signed [15:0] manipulated_variable_cool_in,
   input wire logic loop_burnout_alarm_in,
   input wire logic pv_rate_alarm_in,
   input wire logic heater_fault_alarm_in,
   input wire logic heater_detect_fitted_in,
   output logic [2:0] alarm_out,
   output logic [2:0] aux_out
);
   localparam int NCH = alarm_pkg::NCH;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Sign-extend to the evaluation width
   function automatic logic signed [17:0] sx(input logic signed [15:0] v);
      sx = {{2{v[15]}}, v};
   endfunction

   // Byte-lane merge of a write into the current word
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = strb[b] ? new_w[b*8 +: 8] : old_w[b*8 +: 8];
      end
   endfunction

   // Type code legal for the channel index
   function automatic logic type_ok(input logic [4:0] t, input int ch);
      type_ok = (t <= alarm_pkg::TYPE_LAST) &&
                !(t == alarm_pkg::TYPE_LOOP_BURNOUT && ch != 0);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [4:0] type_q [NCH]; // Alarm type per channel
   logic signed [15:0] high_q [NCH]; // X, or upper deviation H
   logic signed [15:0] low_q [NCH]; // Lower deviation L
   logic [9:0] on_dly_q [NCH]; // Turn-on delay, seconds
   logic [9:0] off_dly_q [NCH]; // Turn-off delay, seconds
   logic heatcool_q; // Heating/cooling control active
   logic a1_assign_q; // Outputs reassigned to alarm one
   logic [5:0] sel_q; // Two-bit source per aux output
   logic fit_s1_q, fit_q; // Strap synchroniser
   logic hidden; // Channel one forced off; aux outputs on source 0 carry heater fault
   assign hidden = fit_q && !a1_assign_q;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic aw_got_q, w_got_q; // Address and data captured
   logic [7:0] aw_addr_q; // Captured write address
   logic [31:0] w_data_q; // Captured write data
   logic [3:0] w_strb_q; // Captured byte enables
   logic bvalid_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [2:0] cond_q; // Qualified conditions
   logic [2:0] out_q; // Delayed alarm states
   logic [2:0] aux_q; // Auxiliary outputs

   assign s_axi_awready_out = !aw_got_q && !bvalid_q;
   assign s_axi_wready_out = !w_got_q && !bvalid_q;
   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rresp_out = rresp_q;
   assign s_axi_rdata_out = rdata_q;

   // Read view of any address; hit flags mapped space
   function automatic logic [32:0] rd_word(input logic [7:0] a);
      logic [1:0] chn;
      logic [31:0] w;
      logic hit;
      chn = a[5:4];
      w = 32'h0000_0000;
      hit = 1'b0;
      if (a[1:0] != 2'h0 || a[7:6] != 2'h0) begin
         hit = 1'b0;
      end else if (a == alarm_pkg::OFS_CTRL) begin
         hit = 1'b1;
         w[alarm_pkg::CTRL_HEATCOOL_BIT] = heatcool_q;
         w[alarm_pkg::CTRL_A1_ASSIGN_BIT] = a1_assign_q;
         w[alarm_pkg::CTRL_SEL_LSB +: 6] = sel_q;
      end else if (a == alarm_pkg::OFS_STAT) begin
         hit = 1'b1;
         w[alarm_pkg::STAT_RAW_LSB +: 3] = cond_q;
         w[alarm_pkg::STAT_OUT_LSB +: 3] = out_q;
         w[alarm_pkg::STAT_AUX_LSB +: 3] = aux_q;
         w[alarm_pkg::STAT_HIDE_BIT] = hidden;
      end else if (chn != 2'h0) begin
         hit = 1'b1;
         unique case (a[3:2])
            alarm_pkg::CH_REG_TYPE: w[4:0] = type_q[chn-2'h1];
            alarm_pkg::CH_REG_HIGH: w = 32'(sx(high_q[chn-2'h1]));
            alarm_pkg::CH_REG_LOW: w = 32'(sx(low_q[chn-2'h1]));
            alarm_pkg::CH_REG_DLY: begin
               w[9:0] = on_dly_q[chn-2'h1];
               w[alarm_pkg::DLY_OFF_LSB +: 10] = off_dly_q[chn-2'h1];
            end
         endcase
      end
      rd_word = {hit, w};
   endfunction

   // Write when both address and data are held or arriving
   wire aw_now = aw_got_q || (s_axi_awvalid_in && s_axi_awready_out);
   wire w_now = w_got_q || (s_axi_wvalid_in && s_axi_wready_out);
   wire do_wr = aw_now && w_now && !bvalid_q;
   wire [7:0] wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr_in;
   logic [32:0] wr_old; // Word at the write address, hit flag on top
   logic [32:0] rd_look; // Word at the read address, hit flag on top
   // Process form so register reads inside the function are tracked
   always_comb begin
      wr_old = rd_word(wr_addr);
      rd_look = rd_word(s_axi_araddr_in);
   end
   wire [31:0] wr_val = merge(wr_old[31:0],
                              w_got_q ? w_data_q : s_axi_wdata_in,
                              w_got_q ? w_strb_q : s_axi_wstrb_in);
   wire [1:0] wr_ch = wr_addr[5:4] - 2'h1;

   // Handshake state of the write and read channels
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= alarm_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= alarm_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end
         aw_got_q <= aw_now && !do_wr;
         w_got_q <= w_now && !do_wr;
         // Response after both halves
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_old[32] ? alarm_pkg::RESP_OKAY
                                  : alarm_pkg::RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
         // Read answers one cycle after acceptance
         if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_look[31:0];
            rresp_q <= rd_look[32] ? alarm_pkg::RESP_OKAY
                                   : alarm_pkg::RESP_SLVERR;
         end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Register writes; illegal type codes leave the old type
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         heatcool_q <= 1'b0;
         a1_assign_q <= 1'b0;
         sel_q <= alarm_pkg::CTRL_SEL_RESET;
         for (int c = 0; c < NCH; c++) begin
            type_q[c] <= alarm_pkg::TYPE_RESET;
            high_q[c] <= alarm_pkg::LIMIT_RESET;
            low_q[c] <= alarm_pkg::LIMIT_RESET;
            on_dly_q[c] <= alarm_pkg::DELAY_RESET;
            off_dly_q[c] <= alarm_pkg::DELAY_RESET;
         end
      end else if (do_wr && wr_old[32]) begin
         if (wr_addr == alarm_pkg::OFS_CTRL) begin
            heatcool_q <= wr_val[alarm_pkg::CTRL_HEATCOOL_BIT];
            a1_assign_q <= wr_val[alarm_pkg::CTRL_A1_ASSIGN_BIT];
            sel_q <= wr_val[alarm_pkg::CTRL_SEL_LSB +: 6];
         end else if (wr_addr[5:4] != 2'h0) begin
            unique case (wr_addr[3:2])
               alarm_pkg::CH_REG_TYPE: begin
                  if (type_ok(wr_val[4:0], int'(wr_ch)) &&
                      !(wr_ch == 2'h0 && hidden)) begin
                     type_q[wr_ch] <= wr_val[4:0];
                  end
               end
               alarm_pkg::CH_REG_HIGH: high_q[wr_ch] <= wr_val[15:0];
               alarm_pkg::CH_REG_LOW: low_q[wr_ch] <= wr_val[15:0];
               alarm_pkg::CH_REG_DLY: begin
                  if (wr_val[9:0] <= alarm_pkg::DELAY_MAX_S) begin
                     on_dly_q[wr_ch] <= wr_val[9:0];
                  end
                  if (wr_val[25:16] <= alarm_pkg::DELAY_MAX_S) begin
                     off_dly_q[wr_ch] <= wr_val[25:16];
                  end
               end
            endcase
         end
      end
   end

   // Strap passes two flops before use
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fit_s1_q <= 1'b0;
         fit_q <= 1'b0;
      end else begin
         fit_s1_q <= heater_detect_fitted_in;
         fit_q <= fit_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One-second tick shared by all delay counters

   logic [31:0] pre_q; // Cycle prescaler
   wire sec_tick = (pre_q == 32'(CYCLES_PER_SEC - 1));
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pre_q <= 32'h0000_0000;
      end else begin
         pre_q <= sec_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel evaluation, standby and delays

   wire signed [17:0] pv = sx(process_value_in);
   wire signed [17:0] sp = sx(set_point_in);
   logic [2:0] raw; // Unqualified conditions
   logic [2:0] sb_type; // Type carries a standby sequence
   logic [2:0] sb_arm_q; // Standby still armed

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire signed [17:0] x = sx(high_q[c]);
      wire signed [17:0] up = sp + x; // Upper limit SP+H/SP+X
      wire signed [17:0] dn = sp - sx(low_q[c]); // Lower limit SP-L
      wire signed [17:0] dnx = sp - x; // SP-X
      wire out_band = (pv > up) || (pv < dn);
      wire in_band = (pv >= dn) && (pv <= up);
      wire overlap = (up < dn);
      wire signed [17:0] mv_hi = heatcool_q ?
         sx(manipulated_variable_in) : sx(manipulated_variable_in);
      wire signed [17:0] mv_lo = heatcool_q ?
         sx(manipulated_variable_cool_in) : sx(manipulated_variable_in);
      logic r;
      // Condition selected by type code
      always_comb begin
         r = 1'b0;
         case (type_q[c])
            alarm_pkg::TYPE_OFF: r = 1'b0;
            alarm_pkg::TYPE_DEV_BAND_OUT: r = out_band;
            alarm_pkg::TYPE_DEV_UPPER: r = (pv >= up);
            alarm_pkg::TYPE_DEV_LOWER: r = (pv <= dnx);
            alarm_pkg::TYPE_DEV_BAND_IN: r = in_band;
            alarm_pkg::TYPE_SB_BAND_OUT: r = out_band && !overlap;
            alarm_pkg::TYPE_SB_UPPER: r = (pv >= up);
            alarm_pkg::TYPE_SB_LOWER: r = (pv <= dnx);
            alarm_pkg::TYPE_ABS_UPPER: r = (pv > x);
            alarm_pkg::TYPE_ABS_LOWER: r = (pv < x);
            alarm_pkg::TYPE_SB_ABS_UPPER: r = (pv > x);
            alarm_pkg::TYPE_SB_ABS_LOWER: r = (pv < x);
            alarm_pkg::TYPE_LOOP_BURNOUT:
               r = (c == 0) && loop_burnout_alarm_in;
            alarm_pkg::TYPE_PV_RATE: r = pv_rate_alarm_in;
            alarm_pkg::TYPE_SP_UPPER: r = (sp > x);
            alarm_pkg::TYPE_SP_LOWER: r = (sp < x);
            alarm_pkg::TYPE_MV_UPPER: r = (mv_hi > x);
            alarm_pkg::TYPE_MV_LOWER: r = (mv_lo < x);
            alarm_pkg::TYPE_RSP_UPPER:
               r = (sx(remote_set_point_in) > x);
            alarm_pkg::TYPE_RSP_LOWER:
               r = (sx(remote_set_point_in) < x);
            default: r = 1'b0;
         endcase
      end
      // Channel one yields to the heater fault alarm
      assign raw[c] = r && !(c == 0 && hidden);
      assign sb_type[c] = (type_q[c] >= alarm_pkg::TYPE_SB_BAND_OUT &&
                           type_q[c] <= alarm_pkg::TYPE_SB_LOWER) ||
                          type_q[c] == alarm_pkg::TYPE_SB_ABS_UPPER ||
                          type_q[c] == alarm_pkg::TYPE_SB_ABS_LOWER;
      // Standby re-arms on type change, clears once condition is off
      logic [4:0] type_seen_q;
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
         if (sys_rst_in) begin
            sb_arm_q[c] <= 1'b1;
            type_seen_q <= alarm_pkg::TYPE_RESET;
         end else begin
            type_seen_q <= type_q[c];
            if (type_seen_q != type_q[c]) begin
               sb_arm_q[c] <= 1'b1;
            end else if (!raw[c]) begin
               sb_arm_q[c] <= 1'b0;
            end
         end
      end
      // Armed in the very cycle of a type change, no one-cycle gap
      wire arm_now = sb_arm_q[c] || (type_seen_q != type_q[c]);
      wire qual = raw[c] && !(sb_type[c] && arm_now);
      // Delay counter: output follows after the set seconds
      logic [9:0] sec_q;
      // Delay picked by the pending state, not the live condition
      wire [9:0] need = cond_q[c] ? on_dly_q[c] : off_dly_q[c];
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
         if (sys_rst_in) begin
            cond_q[c] <= 1'b0;
            out_q[c] <= 1'b0;
            sec_q <= 10'h000;
         end else begin
            cond_q[c] <= qual;
            if (cond_q[c] == out_q[c]) begin
               sec_q <= 10'h000;
            end else if (sec_q >= need) begin
               out_q[c] <= cond_q[c];
               sec_q <= 10'h000;
            end else if (sec_tick) begin
               sec_q <= sec_q + 10'h001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output assignment to auxiliary outputs

   for (genvar k = 0; k < 3; k++) begin : g_aux
      wire [1:0] s = sel_q[2*k +: 2];
      wire src = (s == alarm_pkg::SEL_HEATER) ? heater_fault_alarm_in :
                 (s == 2'h0 && hidden) ? heater_fault_alarm_in :
                 out_q[s];
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
         if (sys_rst_in) begin
            aux_q[k] <= 1'b0;
         end else begin
            aux_q[k] <= src;
         end
      end
   end
   assign aux_out = aux_q;
   assign alarm_out = out_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_rise_req;
      cond_q[0] && !out_q[0] && on_dly_q[0] == 10'h000;
   endsequence
   sequence s_fall_req;
      !cond_q[0] && out_q[0] && off_dly_q[0] == 10'h000;
   endsequence
   AST_OFF_TYPE: assert property (
      type_q[0] == 5'h00 |=> !cond_q[0])
      else $error("type 0 produced an alarm");
   AST_DEV_UPPER: assert property (
      type_q[2] == 5'h02 && pv >= g_ch[2].up |=> cond_q[2])
      else $error("deviation upper alarm missed");
   AST_ABS_LOWER: assert property (
      type_q[0] == 5'h09 && !hidden |=> cond_q[0] == $past(pv < g_ch[0].x))
      else $error("absolute lower alarm wrong");
   AST_ZERO_ON: assert property (
      s_rise_req |=> out_q[0])
      else $error("zero on-delay not immediate");
   AST_ZERO_OFF: assert property (
      s_fall_req |=> !out_q[0])
      else $error("zero off-delay not immediate");
   AST_ON_DELAY: assert property (
      cond_q[0] && !out_q[0] && on_dly_q[0] != 10'h000 && !sec_tick
      |=> !out_q[0] || $past(g_ch[0].sec_q) >= on_dly_q[0])
      else $error("alarm rose before its delay");
   AST_STANDBY: assert property (
      sb_type[0] && g_ch[0].arm_now |=> !cond_q[0])
      else $error("standby did not suppress");
   AST_OVERLAP: assert property (
      type_q[0] == 5'h05 && g_ch[0].overlap |=> !cond_q[0])
      else $error("overlapping band alarm not off");
   AST_AUX_ROUTE: assert property (
      sel_q[3:2] == 2'h1 |=> aux_q[1] == $past(out_q[1]))
      else $error("aux routing mismatch");
   AST_LBA_CH: assert property (
      type_q[1] != 5'h0C && type_q[2] != 5'h0C)
      else $error("loop burnout on a later channel");
endmodule
`default_nettype wire

/* include/alarm_pkg.sv */
`default_nettype none
package alarm_pkg;
   // Channel and output counts
   localparam int NCH = 3;
   localparam int NAUX = 3;
   // Compared quantities are signed engineering counts
   localparam int DW = 16;
   localparam int EW = 18;
   // Delay counter width and limit in seconds
   localparam int DLW = 10;
   localparam logic [9:0] DELAY_MAX_S = 10'd999;
   // Clock figures and one second in cycles
   localparam longint CLK_PERIOD_NS = 8;
   localparam longint SECOND_NS = 1_000_000_000;
   localparam int CYCLES_PER_SEC = int'(SECOND_NS / CLK_PERIOD_NS);
   // Alarm type codes
   typedef enum logic [4:0] {
      TYPE_OFF = 5'h00, TYPE_DEV_BAND_OUT = 5'h01, TYPE_DEV_UPPER = 5'h02,
      TYPE_DEV_LOWER = 5'h03, TYPE_DEV_BAND_IN = 5'h04,
      TYPE_SB_BAND_OUT = 5'h05, TYPE_SB_UPPER = 5'h06,
      TYPE_SB_LOWER = 5'h07, TYPE_ABS_UPPER = 5'h08,
      TYPE_ABS_LOWER = 5'h09, TYPE_SB_ABS_UPPER = 5'h0A,
      TYPE_SB_ABS_LOWER = 5'h0B, TYPE_LOOP_BURNOUT = 5'h0C,
      TYPE_PV_RATE = 5'h0D, TYPE_SP_UPPER = 5'h0E, TYPE_SP_LOWER = 5'h0F,
      TYPE_MV_UPPER = 5'h10, TYPE_MV_LOWER = 5'h11,
      TYPE_RSP_UPPER = 5'h12, TYPE_RSP_LOWER = 5'h13
   } alarm_type_t;
   localparam alarm_type_t TYPE_RESET = TYPE_DEV_UPPER;
   localparam logic [4:0] TYPE_LAST = 5'h13;
   // Register map, byte addresses
   localparam int AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [1:0] CH_REG_TYPE = 2'h0;
   localparam logic [1:0] CH_REG_HIGH = 2'h1;
   localparam logic [1:0] CH_REG_LOW = 2'h2;
   localparam logic [1:0] CH_REG_DLY = 2'h3;
   // Control fields
   localparam int CTRL_HEATCOOL_BIT = 0;
   localparam int CTRL_A1_ASSIGN_BIT = 1;
   localparam int CTRL_SEL_LSB = 8;
   localparam logic [5:0] CTRL_SEL_RESET = 6'h24;
   localparam logic [1:0] SEL_HEATER = 2'h3;
   // Status fields
   localparam int STAT_RAW_LSB = 0;
   localparam int STAT_OUT_LSB = 4;
   localparam int STAT_AUX_LSB = 8;
   localparam int STAT_HIDE_BIT = 12;
   // Delay register field
   localparam int DLY_OFF_LSB = 16;
   // Reset values of limits and delays
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [9:0] DELAY_RESET = 10'h000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* test/core_model.sv */
`default_nettype none
// Behavioural loop core that supplies the compared quantities
module core_model (
   input wire logic clk_in,
   output logic signed [15:0] pv_out,
   output logic signed [15:0] sp_out,
   output logic signed [15:0] rsp_out,
   output logic signed [15:0] mv_out,
   output logic flg_out,
   output logic htr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet values at time zero
   initial begin
      {pv_out, sp_out, rsp_out, mv_out} = '0;
      {flg_out, htr_out} = '0;
   end
   // New sample taken just after an edge
   task automatic put(input logic [15:0] pv, sp, rsp, mv,
                      input logic flg, htr);
      @(posedge clk_in);
      pv_out <= pv;
      sp_out <= sp;
      rsp_out <= rsp;
      mv_out <= mv;
      flg_out <= flg;
      htr_out <= htr;
   endtask
endmodule
`default_nettype wire

/* test/process_alarm_evaluator_tb_top.sv */
`default_nettype none
module process_alarm_evaluator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic heater_detect_fitted_in = 1'h0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
   logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
   logic s_axi_rready_in = 1'h0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic [31:0] s_axi_rdata_out;
   logic [2:0] alarm_out, aux_out;
   wire signed [15:0] process_value_in, set_point_in;
   wire signed [15:0] remote_set_point_in, manipulated_variable_in;
   wire flg, heater_fault_alarm_in;
   logic signed [15:0] mv_cool = 16'h0000;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   logic [31:0] rd_d;
   logic [1:0] rsp;
   ////////////////////////////////////////////////////////////////////////
   // Clock, design and core model
   always #4 clk_in = ~clk_in;
   process_alarm_evaluator #(.CYCLES_PER_SEC(10)) dut (.clk_in, .sys_rst_in,
      .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
      .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
      .process_value_in, .set_point_in, .remote_set_point_in,
      .manipulated_variable_in, .manipulated_variable_cool_in(mv_cool),
      .loop_burnout_alarm_in(flg),
      .pv_rate_alarm_in(flg), .heater_fault_alarm_in,
      .heater_detect_fitted_in, .alarm_out, .aux_out);
   core_model core (.clk_in, .pv_out(process_value_in), .sp_out(set_point_in),
      .rsp_out(remote_set_point_in), .mv_out(manipulated_variable_in),
      .flg_out(flg), .htr_out(heater_fault_alarm_in));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and run end
   task automatic end_sim();
      if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Bus master tasks: hold each channel until its ready is sampled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'h1;
      s_axi_wvalid_in <= 1'h1;
      s_axi_bready_in <= 1'h1;
      forever begin
         @(posedge clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
         if (s_axi_bvalid_out) break;
      end
      rsp = s_axi_bresp_out;
      s_axi_bready_in <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'h1;
      s_axi_rready_in <= 1'h1;
      forever begin
         @(posedge clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
         if (s_axi_rvalid_out) break;
      end
      rd_d = s_axi_rdata_out;
      rsp = s_axi_rresp_out;
      s_axi_rready_in <= 1'h0;
   endtask
   // One type on channel one: threshold 10, set point as given
   task automatic ty(input logic [4:0] t, input logic [15:0] pv, sp, rs, mv,
                     input logic e);
      core.put(pv, sp, rs, mv, e, 1'h0);
      wr(8'h10, {27'h0, t});
      repeat (6) @(posedge clk_in);
      rd(8'h04);
      chk({31'h0, rd_d[0]}, {31'h0, e});
      chk({31'h0, alarm_out[0]}, {31'h0, e});
      chk({31'h0, aux_out[0]}, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      rd(8'h10);
      chk(rd_d, 32'h2);
      wr(8'h14, 32'hA);
      wr(8'h18, 32'h5);
      ty(5'h00, 16'h3E7, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h01, 16'h6F, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h01, 16'h5E, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h01, 16'h6E, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h02, 16'h6E, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h02, 16'h6D, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h03, 16'h5A, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h03, 16'h5B, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h04, 16'h5F, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h04, 16'h5E, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h06, 16'h6E, 16'h64, 16'h0, 16'h0, 1'h0);
      core.put(16'h64, 16'h64, 16'h0, 16'h0, 1'h0, 1'h0);
      ty(5'h06, 16'h6E, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h08, 16'hB, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h08, 16'hA, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h09, 16'h9, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h0A, 16'hB, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h0C, 16'h0, 16'h64, 16'h0, 16'h0, 1'h1);
      ty(5'h0D, 16'h0, 16'h64, 16'h0, 16'h0, 1'h0);
      ty(5'h0E, 16'h0, 16'hB, 16'h0, 16'h0, 1'h1);
      ty(5'h0F, 16'h0, 16'hA, 16'h0, 16'h0, 1'h0);
      ty(5'h10, 16'h0, 16'h64, 16'h0, 16'hB, 1'h1);
      ty(5'h11, 16'h0, 16'h64, 16'h0, 16'h9, 1'h1);
      ty(5'h12, 16'h0, 16'h64, 16'hB, 16'h0, 1'h1);
      ty(5'h13, 16'h0, 16'h64, 16'hA, 16'h0, 1'h0);
      // Heating/cooling: lower limit looks at the cooling level only
      wr(8'h00, 32'h0000_2401);
      mv_cool <= 16'h9;
      ty(5'h11, 16'h0, 16'h64, 16'h0, 16'hB, 1'h1);
      wr(8'h00, 32'h0000_2400);
      // Upper deviation below lower one: bands overlap
      wr(8'h14, 32'hFFFF_FFF0);
      ty(5'h05, 16'h0, 16'h64, 16'h0, 16'h0, 1'h0);
      wr(8'h14, 32'hA);
      // Delays: on 2 s accepted, off 1000 s refused
      ty(5'h02, 16'h64, 16'h64, 16'h0, 16'h0, 1'h0);
      wr(8'h1C, 32'h03E8_0002);
      rd(8'h1C);
      chk(rd_d, 32'h2);
      core.put(16'h6E, 16'h64, 16'h0, 16'h0, 1'h0, 1'h0);
      repeat (8) @(posedge clk_in);
      chk({31'h0, alarm_out[0]}, 32'h0);
      repeat (22) @(posedge clk_in);
      chk({31'h0, alarm_out[0]}, 32'h1);
      // Loop burnout and out-of-range codes refused on channel two
      wr(8'h20, 32'hC);
      wr(8'h20, 32'h14);
      rd(8'h20);
      chk(rd_d, 32'h2);
      // Unmapped place
      rd(8'hF0);
      chk(rd_d, 32'h0);
      chk({30'h0, rsp}, 32'h2);
      wr(8'hF0, 32'h1);
      chk({30'h0, rsp}, 32'h2);
      // Heater variant hides channel one and routes the heater fault
      heater_detect_fitted_in <= 1'h1;
      core.put(16'h0, 16'h64, 16'h0, 16'h0, 1'h0, 1'h1);
      repeat (8) @(posedge clk_in);
      rd(8'h04);
      chk({31'h0, rd_d[12]}, 32'h1);
      chk({31'h0, aux_out[0]}, 32'h1);
      end_sim();
   end
endmodule
`default_nettype wire
